// [rtl/ocae_pkg.sv]
// Purpose : shared constants and carriers for the opcode check, alignment and endian block
// Assumes : one core clock, instruction and load/store traffic from logic on the same clock
// Notes   : opcode values below are this block's own decode map
//
// What this block does
// - with misalign checking on, an access whose address is not a size multiple traps.
// - with checking off, the low address bits are cleared and the access goes on quietly.
// - a trap drains all work in flight so the pipes are empty before the handler starts.
// - an unimplemented major or minor opcode field raises an exception.
// - an unused register field holding a nonzero value raises an exception.
// - unknown unit-zero opcodes give the opcode trap, units one to seven their own trap.
// - unscaled load-address forms are illegal, the scaled triadic form stays legal.
// - the immediate exchange-with-memory form is illegal, the triadic form stays legal.
// - data may be big-endian (native) or little-endian.
// - instruction fetches are always big-endian.
// - little-endian keeps the address and reverses the bytes of each item.
// - quad-word transfers are reversed in little-endian mode like doubles.
// - single bytes are never swapped.
package ocae_pkg;

   // ***************************************************************
   // access sizes
   // ***************************************************************
   typedef enum logic [2:0] {
      SZ_BYTE = 3'h0,
      SZ_HALF = 3'h1,
      SZ_WORD = 3'h2,
      SZ_DBL  = 3'h3,
      SZ_QUAD = 3'h4
   } ocae_size_t;

   // ***************************************************************
   // decode map
   // ***************************************************************
   localparam logic [5:0]  OP_SPECIAL_UNIT_ZERO = 6'h20;
   localparam logic [5:0]  OP_SPECIAL_UNIT_ONE  = 6'h21;
   localparam logic [5:0]  OP_SPECIAL_UNIT_LAST = 6'h27;
   localparam logic [5:0]  OP_TRIADIC           = 6'h3d;
   // majors that exist; exchange-immediate (0x00,0x01) and load-address
   // immediate (0x0c..0x0f) are left out on purpose
   localparam logic [63:0] IMPL_MAJOR           = 64'hf0ff_00ff_ffff_0ff0;
   // majors whose low five bits are immediate, not a register field
   localparam logic [63:0] IMM_MAJOR            = 64'hf000_0000_ffff_fff0;
   localparam logic [31:0] SPECIAL_UNIT_ZERO_MINORS          = 32'h0000_000f;
   localparam logic [31:0] SFU1_MINORS          = 32'h0fff_ffff;
   localparam logic [63:0] TRI_MINORS           = 64'h0000_ffff_0000_ffff;
   localparam logic [5:0]  TRI_LOAD_ADDRESS     = 6'h0f;
   localparam logic [5:0]  TRI_XMEM             = 6'h00;
   localparam logic [4:0]  TRI_SCALED           = 5'h10;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic        unimp;
      logic        sfu;
      logic [2:0]  sfu_num;
   } ocae_dec_res_t;

   typedef struct packed {
      logic        store;
      logic        fetch;
      ocae_size_t  size;
      logic [31:0] addr;
      logic [127:0] data;
   } ocae_ls_req_t;

   typedef struct packed {
      logic        fetch;
      ocae_size_t  size;
      logic [127:0] data;
   } ocae_ls_rsp_t;

   localparam logic [3:0] OUTSTANDING_MAX = 4'hf;

endpackage : ocae_pkg

// [rtl/ocae_core.sv]
// Purpose : instruction legality checks, load/store alignment and byte order, trap drain
// Assumes : all inputs come from logic on mclk_i; one response per accepted memory request
// Notes   : decode result and memory request are registered, one cycle after the input
`timescale 1ns/1ps
module ocae_core
   import ocae_pkg::*;
(
   // clock and reset
   input  wire logic          mclk_i,
   input  wire logic          resetn_i,
   input  wire logic          ce_i,
   // modes
   input  wire logic          little_endian_i,
   input  wire logic          misalign_check_en_i,
   // instruction decode
   input  wire logic          dec_valid_i,
   input  wire logic [31:0]   dec_instr_i,
   output logic               dec_done_o,
   output ocae_dec_res_t      dec_res_o,
   // load/store requests from the core
   input  wire logic          ls_valid_i,
   output logic               ls_ready_o,
   input  wire ocae_ls_req_t  ls_req_i,
   output logic               misalign_exc_o,
   // memory side
   output logic               mem_valid_o,
   input  wire logic          mem_ready_i,
   output ocae_ls_req_t       mem_req_o,
   input  wire logic          mem_rvalid_i,
   input  wire ocae_ls_rsp_t  mem_rsp_i,
   output logic               ld_valid_o,
   output logic [127:0]       ld_data_o,
   // trap drain
   input  wire logic          trap_i,
   output logic               draining_o,
   output logic               handler_go_o
);

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [4:0] size_bytes(input ocae_size_t s);
      logic [4:0] n;
      n = 5'h01;
      unique case (s)
         SZ_HALF: n = 5'h02;
         SZ_WORD: n = 5'h04;
         SZ_DBL:  n = 5'h08;
         SZ_QUAD: n = 5'h10;
         default: n = 5'h01;
      endcase
      return n;
   endfunction : size_bytes

   function automatic logic [3:0] align_mask(input ocae_size_t s);
      logic [4:0] n;
      n = size_bytes(s);
      return 4'(n - 5'h01);
   endfunction : align_mask

   // ***************************************************************
   // trap drain state
   // ***************************************************************
   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_DRAIN = 3'b010,
      ST_GO    = 3'b100
   } ocae_state_t;

   ocae_state_t   state_q;
   logic [3:0]    outstanding_q;
   logic          out_valid_q;
   logic          accept;
   logic          mem_fire;

   assign mem_fire = out_valid_q && mem_ready_i;
   // requests stall while draining and while the counter reads OUTSTANDING_MAX
   assign ls_ready_o = (state_q == ST_RUN) && !trap_i
                       && (!out_valid_q || mem_ready_i)
                       && (outstanding_q != OUTSTANDING_MAX);
   assign accept     = ls_valid_i && ls_ready_o;

   // ***************************************************************
   // instruction legality
   // ***************************************************************
   logic [5:0]    major;
   logic [10:0]   minor;
   logic          bad_major;
   logic          bad_minor;
   logic          bad_field;
   logic          is_sfu;
   logic [2:0]    sfu_num;

   assign major  = dec_instr_i[31:26];
   assign minor  = dec_instr_i[15:5];
   assign is_sfu = (major >= OP_SPECIAL_UNIT_ZERO) && (major <= OP_SPECIAL_UNIT_LAST);
   assign sfu_num = major[2:0];

   always_comb begin
      bad_major = !IMPL_MAJOR[major];
      bad_minor = 1'b0;
      bad_field = 1'b0;
      if (major == OP_SPECIAL_UNIT_ZERO) begin
         bad_minor = !SPECIAL_UNIT_ZERO_MINORS[minor[10:6]];
         // unit zero requires the s2 field to be zero
         bad_field = (dec_instr_i[4:0] != 5'h00);
      end else if (major == OP_SPECIAL_UNIT_ONE) begin
         bad_minor = !SFU1_MINORS[minor[10:6]];
      end else if (is_sfu) begin
         // units two to seven have no implemented minor opcodes
         bad_minor = 1'b1;
      end else if (major == OP_TRIADIC) begin
         bad_minor = !TRI_MINORS[minor[10:5]];
         if (minor[10:5] == TRI_LOAD_ADDRESS) begin
            bad_minor = bad_minor || (minor[4:0] != TRI_SCALED);
         end else if (minor[10:5] == TRI_XMEM) begin
            bad_minor = bad_minor || (minor[4:0] != 5'h00 && minor[4:0] != TRI_SCALED);
         end else begin
            bad_minor = bad_minor || (minor[4:0] != 5'h00);
         end
      end else if (!IMM_MAJOR[major]) begin
         bad_field = (dec_instr_i[4:0] != 5'h00);
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dec_done_o <= 1'b0;
         dec_res_o  <= '0;
      end else if (ce_i) begin
         dec_done_o <= dec_valid_i;
         if (dec_valid_i) begin
            dec_res_o.sfu     <= is_sfu && (major != OP_SPECIAL_UNIT_ZERO) && bad_minor;
            dec_res_o.sfu_num <= is_sfu ? sfu_num : 3'h0;
            dec_res_o.unimp   <= bad_major || bad_field
                                 || (bad_minor && !(is_sfu && major != OP_SPECIAL_UNIT_ZERO));
         end
      end
   end

   // ***************************************************************
   // alignment and store-side byte order
   // ***************************************************************
   logic [3:0]    amask;
   logic          misaligned;
   logic          swap_st;
   logic [127:0]  st_swapped;

   assign amask = align_mask(ls_req_i.size);
   // low address bits tested per size
   assign misaligned = (ls_req_i.addr[3:0] & amask) != 4'h0;
   assign swap_st = little_endian_i && !ls_req_i.fetch && (ls_req_i.size != SZ_BYTE);

   // ***************************************************************
   // byte reversal, both directions
   // ***************************************************************
   logic [127:0]  ld_swapped;
   logic [4:0]    st_n;
   logic [4:0]    ld_n;

   assign st_n = size_bytes(ls_req_i.size);
   assign ld_n = size_bytes(mem_rsp_i.size);

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_lane
         always_comb begin
            st_swapped[gi*8 +: 8] = 8'h00;
            ld_swapped[gi*8 +: 8] = 8'h00;
            if (5'(gi) < st_n) begin
               st_swapped[gi*8 +: 8] = ls_req_i.data[(st_n - 5'(gi) - 5'h01)*8 +: 8];
            end
            if (5'(gi) < ld_n) begin
               ld_swapped[gi*8 +: 8] = mem_rsp_i.data[(ld_n - 5'(gi) - 5'h01)*8 +: 8];
            end
         end
      end
   endgenerate

   // ***************************************************************
   // memory request stage
   // ***************************************************************
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_valid_q    <= 1'b0;
         mem_req_o      <= '0;
         misalign_exc_o <= 1'b0;
      end else if (ce_i) begin
         misalign_exc_o <= 1'b0;
         if (mem_fire) begin
            out_valid_q <= 1'b0;
         end
         if (accept) begin
            if (misaligned && misalign_check_en_i) begin
               misalign_exc_o <= 1'b1;
            end else begin
               out_valid_q      <= 1'b1;
               mem_req_o.store  <= ls_req_i.store;
               mem_req_o.fetch  <= ls_req_i.fetch;
               mem_req_o.size   <= ls_req_i.size;
               mem_req_o.addr   <= {ls_req_i.addr[31:4], ls_req_i.addr[3:0] & ~amask};
               mem_req_o.data   <= swap_st ? st_swapped : ls_req_i.data;
            end
         end
      end
   end

   assign mem_valid_o = out_valid_q;

   // ***************************************************************
   // load return path
   // ***************************************************************
   // big-endian native, little-endian swaps
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ld_valid_o <= 1'b0;
         ld_data_o  <= '0;
      end else if (ce_i) begin
         ld_valid_o <= mem_rvalid_i;
         if (mem_rvalid_i) begin
            ld_data_o <= (little_endian_i && !mem_rsp_i.fetch && mem_rsp_i.size != SZ_BYTE)
                         ? ld_swapped : mem_rsp_i.data;
         end
      end
   end

   // ***************************************************************
   // in-flight tracking and trap drain
   // ***************************************************************
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         outstanding_q <= 4'h0;
      end else if (ce_i) begin
         unique case ({mem_fire, mem_rvalid_i && outstanding_q != 4'h0})
            2'b10:   outstanding_q <= outstanding_q + 4'h1;
            2'b01:   outstanding_q <= outstanding_q - 4'h1;
            default: outstanding_q <= outstanding_q;
         endcase
      end
   end

   // the handler waits on memory answers: a lost response stalls the trap
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_RUN;
      end else if (ce_i) begin
         unique case (state_q)
            ST_RUN: begin
               if (trap_i) begin
                  state_q <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               if (!out_valid_q && outstanding_q == 4'h0 && !mem_rvalid_i) begin
                  state_q <= ST_GO;
               end
            end
            ST_GO: begin
               state_q <= ST_RUN;
            end
         endcase
      end
   end

   assign draining_o   = (state_q == ST_DRAIN);
   assign handler_go_o = (state_q == ST_GO);

endmodule : ocae_core

// [tb/ocae_core_sva.sv]
// Purpose : port-level checks of decode, alignment, byte order and trap drain
// Assumes : one clock domain, reset active low
// Notes   : bound into every ocae_core instance
`timescale 1ns/1ps
module ocae_core_sva
   import ocae_pkg::*;
(
   // clock and reset
   input wire logic         mclk_i,
   input wire logic         resetn_i,
   input wire logic         ce_i,
   // modes and requests
   input wire logic         little_endian_i,
   input wire logic         misalign_check_en_i,
   input wire logic         dec_valid_i,
   input wire logic         ls_valid_i,
   input wire ocae_ls_req_t ls_req_i,
   input wire logic         mem_ready_i,
   input wire logic         mem_rvalid_i,
   input wire ocae_ls_rsp_t mem_rsp_i,
   input wire logic         trap_i,
   // design outputs
   input wire logic         dec_done_o,
   input wire logic         ls_ready_o,
   input wire logic         misalign_exc_o,
   input wire logic         mem_valid_o,
   input wire ocae_ls_req_t mem_req_o,
   input wire logic         ld_valid_o,
   input wire logic [127:0] ld_data_o,
   input wire logic         draining_o,
   input wire logic         handler_go_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   function automatic logic [31:0] lowm(input ocae_size_t s);
      return {28'h000_0000, (4'h1 << s) - 4'h1};
   endfunction : lowm

   // ***************************************************************
   // sequences
   // ***************************************************************
   sequence s_acc;
      ce_i && ls_valid_i && ls_ready_o;
   endsequence
   sequence s_bad;
      misalign_check_en_i && |(ls_req_i.addr & lowm(ls_req_i.size));
   endsequence
   sequence s_le_word_st;
      little_endian_i && ls_req_i.store && !ls_req_i.fetch && ls_req_i.size == SZ_WORD;
   endsequence
   sequence s_trap;
      ce_i && trap_i && !draining_o && !handler_go_o;
   endsequence

   // ***************************************************************
   // assertions
   // ***************************************************************
   a_dec_done_next: assert property (ce_i && dec_valid_i |=> dec_done_o)
      else $error("decode result missing");
   a_misalign_trap: assert property (s_acc ##0 s_bad |=> misalign_exc_o)
      else $error("misaligned access not trapped");
   a_silent_align: assert property (s_acc ##0 !misalign_check_en_i |=> mem_valid_o
      && mem_req_o.addr == ($past(ls_req_i.addr) & ~lowm($past(ls_req_i.size))))
      else $error("address not aligned down");
   a_issue_aligned: assert property (mem_valid_o
      |-> !(|(mem_req_o.addr & lowm(mem_req_o.size))))
      else $error("misaligned address issued");
   a_req_hold: assert property (mem_valid_o && !mem_ready_i
      |=> mem_valid_o && $stable(mem_req_o))
      else $error("memory request dropped");
   a_le_word_swap: assert property (s_acc ##0 s_le_word_st
      ##0 !(misalign_check_en_i && |(ls_req_i.addr & lowm(ls_req_i.size)))
      |=> mem_req_o.data[31:0] == 32'({<<8{$past(ls_req_i.data[31:0])}}))
      else $error("word store not byte reversed");
   a_byte_same: assert property (ce_i && mem_rvalid_i && mem_rsp_i.size == SZ_BYTE
      |=> ld_valid_o && ld_data_o[7:0] == $past(mem_rsp_i.data[7:0]))
      else $error("byte load altered");
   a_fetch_big: assert property (ce_i && mem_rvalid_i && mem_rsp_i.fetch
      |=> ld_data_o == $past(mem_rsp_i.data))
      else $error("fetch data swapped");
   a_trap_drain: assert property (s_trap |=> draining_o && !ls_ready_o)
      else $error("trap did not start drain");
   a_drain_bound: assert property ($rose(draining_o) |-> ##[1:300] handler_go_o)
      else $error("drain never finished");
   a_go_clean: assert property (handler_go_o |-> $past(draining_o) && !mem_valid_o)
      else $error("handler started with work in flight");
endmodule : ocae_core_sva

bind ocae_core ocae_core_sva i_ocae_core_sva (.mclk_i(mclk_i), .resetn_i(resetn_i),
   .ce_i(ce_i), .little_endian_i(little_endian_i), .misalign_check_en_i(misalign_check_en_i),
   .dec_valid_i(dec_valid_i), .ls_valid_i(ls_valid_i), .ls_req_i(ls_req_i),
   .mem_ready_i(mem_ready_i), .mem_rvalid_i(mem_rvalid_i), .mem_rsp_i(mem_rsp_i),
   .trap_i(trap_i), .dec_done_o(dec_done_o), .ls_ready_o(ls_ready_o),
   .misalign_exc_o(misalign_exc_o), .mem_valid_o(mem_valid_o), .mem_req_o(mem_req_o),
   .ld_valid_o(ld_valid_o), .ld_data_o(ld_data_o), .draining_o(draining_o),
   .handler_go_o(handler_go_o));

// [tb/ocae_mem_model.sv]
// Purpose : big-endian byte memory answering load, store and fetch requests
// Assumes : requests held until ready; one response per request, in order
// Notes   : slow mode toggles ready and stretches latency to four cycles
`timescale 1ns/1ps
module ocae_mem_model
   import ocae_pkg::*;
(
   // clock and mode
   input  wire logic         mclk_i,
   input  wire logic         slow_i,
   // request side
   input  wire logic         req_valid_i,
   input  wire ocae_ls_req_t req_i,
   output logic              ready_o = 1'b1,
   // response side
   output logic              rvalid_o = 1'b0,
   output ocae_ls_rsp_t      rsp_o = '0,
   output logic              busy_o = 1'b0
);
   logic [7:0]   mem [logic [31:0]];
   ocae_ls_rsp_t q [$];
   int           due [$];
   int           cyc = 0;
   int           n;
   logic [31:0]  a;
   ocae_ls_rsp_t r;

   always @(posedge mclk_i) begin
      cyc++;
      if (req_valid_i && ready_o) begin
         n = 1 << req_i.size;
         r = '0;
         r.fetch = req_i.fetch;
         r.size = req_i.size;
         for (int i = 0; i < n; i++) begin
            a = req_i.addr + i;
            if (req_i.store) mem[a] = req_i.data[8*(n-1-i) +: 8];
            else r.data[8*(n-1-i) +: 8] = mem.exists(a) ? mem[a] : 8'h00;
         end
         q.push_back(r);
         due.push_back(cyc + (slow_i ? 4 : 1));
      end
      #1;
      ready_o = slow_i ? ~ready_o : 1'b1;
      rvalid_o = 1'b0;
      // idle data keeps moving so nothing stale can pass for a reply
      rsp_o = ~rsp_o;
      if (q.size() > 0 && due[0] <= cyc) begin
         rvalid_o = 1'b1;
         rsp_o = q.pop_front();
         void'(due.pop_front());
      end
      busy_o = q.size() != 0;
   end
endmodule : ocae_mem_model

// [tb/opcode_check_align_endian_test.sv]
// Purpose : self-checking bench for decode legality, alignment, byte order and trap drain
// Assumes : inputs driven 2 ns after the rising edge, memory model moves at 1 ns
// Notes   : clock enable held high apart from one decode step that checks freeze holds the result
`timescale 1ns/1ps
module opcode_check_align_endian_test;
   import ocae_pkg::*;
   logic mclk_i = 0, resetn_i = 0, ce_i = 1, little_endian_i = 0, misalign_check_en_i = 1;
   logic dec_valid_i = 0, dec_done_o, ls_valid_i = 0, ls_ready_o, misalign_exc_o;
   logic mem_valid_o, mem_ready_i, mem_rvalid_i, ld_valid_o, trap_i = 0;
   logic draining_o, handler_go_o, slow = 0, mem_busy;
   logic [31:0] dec_instr_i = '0;
   logic [127:0] ld_data_o;
   ocae_dec_res_t dec_res_o;
   ocae_ls_req_t ls_req_i = '0, mem_req_o;
   ocae_ls_rsp_t mem_rsp_i;
   int errors = 0, checks_done = 0, cycles = 0;
   const logic [127:0] pat = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;

   ocae_core i_ocae_core (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i),
      .little_endian_i(little_endian_i), .misalign_check_en_i(misalign_check_en_i),
      .dec_valid_i(dec_valid_i), .dec_instr_i(dec_instr_i), .dec_done_o(dec_done_o),
      .dec_res_o(dec_res_o), .ls_valid_i(ls_valid_i), .ls_ready_o(ls_ready_o),
      .ls_req_i(ls_req_i), .misalign_exc_o(misalign_exc_o), .mem_valid_o(mem_valid_o),
      .mem_ready_i(mem_ready_i), .mem_req_o(mem_req_o), .mem_rvalid_i(mem_rvalid_i),
      .mem_rsp_i(mem_rsp_i), .ld_valid_o(ld_valid_o), .ld_data_o(ld_data_o),
      .trap_i(trap_i), .draining_o(draining_o), .handler_go_o(handler_go_o));
   ocae_mem_model i_ocae_mem_model (.mclk_i(mclk_i), .slow_i(slow),
      .req_valid_i(mem_valid_o), .req_i(mem_req_o), .ready_o(mem_ready_i),
      .rvalid_o(mem_rvalid_i), .rsp_o(mem_rsp_i), .busy_o(mem_busy));

   initial forever #4 mclk_i = ~mclk_i;
   // hang guard: whole run needs well under 2000 cycles
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_of_test();
      end
   end

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   task automatic step(); @(posedge mclk_i); #2; endtask : step
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [127:0] rev(input logic [127:0] v, input int n);
      rev = '0;
      for (int i = 0; i < n; i++) rev[8*i +: 8] = v[8*(n-1-i) +: 8];
   endfunction : rev
   function automatic logic [127:0] item(input int s);
      return pat & ~('1 << (8 << s));
   endfunction : item
   // request held until an edge that sees ready
   task automatic ls(input logic st, input logic f, input int s, input logic [31:0] ad,
                     input logic [127:0] d, input logic le);
      little_endian_i = le;
      ls_req_i = '{st, f, ocae_size_t'(s), ad, d};
      ls_valid_i = 1;
      for (int i = 0; i < 50 && !ls_ready_o; i++) step();
      step();
      ls_valid_i = 0;
   endtask : ls
   task automatic drain();
      for (int i = 0; i < 60 && (mem_busy || mem_valid_o); i++) step();
      step();
      step();
   endtask : drain
   task automatic ld(input int s, input logic [31:0] ad, input logic le, input logic f,
                     input logic [127:0] exp);
      ls(0, f, s, ad, '0, le);
      for (int i = 0; i < 60 && !ld_valid_o; i++) step();
      chk(ld_valid_o, 1);
      chk(ld_data_o, exp);
      drain();
   endtask : ld

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_decode();
      logic [31:0] ins [15] = '{32'h8000_0000, 32'h8000_2800, 32'h8400_e000, 32'h8800_0000,
         32'h9c00_0000, 32'ha000_0000, 32'hc000_0001, 32'hc000_0000, 32'h0000_0000,
         32'hf400_0000, 32'hf400_3e00, 32'hf400_3c00, 32'h3000_0000, 32'hf400_0420,
         32'h8000_0001};
      logic [4:0] ex [15] = '{5'h00, 5'h10, 5'h09, 5'h0a, 5'h0f, 5'h10, 5'h10, 5'h00,
         5'h10, 5'h00, 5'h00, 5'h10, 5'h10, 5'h10, 5'h10};
      for (int i = 0; i < 15; i++) begin
         dec_valid_i = 1;
         dec_instr_i = ins[i];
         step();
         chk(dec_done_o, 1);
         chk(dec_res_o, ex[i]);
      end
      // enable low must hold the last result
      ce_i = 0;
      dec_instr_i = 32'h8000_0000;
      step();
      chk(dec_res_o, 5'h10);
      ce_i = 1;
      step();
      chk(dec_res_o, 5'h00);
      dec_valid_i = 0;
   endtask : t_decode
   task automatic t_endian();
      for (int s = 0; s < 5; s++) begin
         ls(1, 0, s, 32'h100 + 32 * s, item(s), 1);
         drain();
         ld(s, 32'h100 + 32 * s, 1, 0, item(s));
         ld(s, 32'h100 + 32 * s, 0, 0, rev(item(s), 1 << s));
      end
      ls(1, 0, 2, 32'h200, 32'h89ab_cdef, 0);
      drain();
      ld(2, 32'h200, 1, 1, 32'h89ab_cdef);
   endtask : t_endian
   task automatic t_align();
      slow = 1;
      for (int s = 1; s < 5; s++) begin
         ls(0, 0, s, 32'h100 + 32 * s + ((1 << s) >> 1), '0, 1);
         chk(misalign_exc_o, 1);
         chk(mem_valid_o, 0);
         step();
      end
      misalign_check_en_i = 0;
      for (int s = 1; s < 5; s++) begin
         ld(s, 32'h100 + 32 * s + (1 << s) - 1, 1, 0, item(s));
      end
      misalign_check_en_i = 1;
   endtask : t_align
   task automatic t_trap();
      ls(0, 0, 2, 32'h200, '0, 0);
      trap_i = 1;
      step();
      trap_i = 0;
      chk(draining_o, 1);
      chk(ls_ready_o, 0);
      for (int i = 0; i < 100 && !handler_go_o; i++) step();
      chk(handler_go_o, 1);
      chk(mem_busy, 0);
      step();
      chk(draining_o, 0);
      slow = 0;
   endtask : t_trap

   initial begin
      repeat (10) @(posedge mclk_i);
      #2 resetn_i = 1;
      step();
      t_decode();
      t_endian();
      t_align();
      t_trap();
      end_of_test();
   end
endmodule : opcode_check_align_endian_test
